// ### design/psi_unit.sv
// Operation
// - pc is 15 bits; low byte software visible, upper seven only via latch
// - every reset source clears the program counter
// - writing pc low byte loads upper bits from the latch at once
// - call loads eleven operand bits, upper four from latch bits 6..3
// - call via w takes low byte from w, upper from latch
// - branch by w loads pc plus one plus unsigned w
// - relative branch loads pc plus one plus signed operand
// - sixteen entry return stack of 15 bit words, outside memory spaces
// - calls and interrupts push, returns pop; latch untouched
// - push increments index then writes; pop reads then decrements
// - stack index is five bits resetting to 0x1F meaning empty
// - top of stack high and low show and modify the indexed entry
// - with fault reset off the stack wraps circularly
// - overflow and underflow flags set whether or not reset enabled
// - with fault reset on, overflow or underflow resets the device
// - indirect port access goes to the pointer's location
// - pointer at an indirect port reads zero and blocks writes
// - indirect address is pointer high and low bytes joined
// - indirect 0x000..0xFFF map straight to absolute addresses
// - indirect 0x2000..0x29AF chain the 80 byte banks, gaps read zero
// - top pointer bit selects program memory, low byte, no write, extra cycle
//
// Our own choice: the APB interface to the registers.
module psi_unit
  import psi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cfg_reset_en_pin,
  input wire psi_cmd_t i_cmd,
  input wire psi_ind_t i_ind,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] i_prog_rdata,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [14:0] o_pc,
  output logic [11:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  output logic [14:0] o_prog_addr,
  output logic o_prog_rd,
  output logic [7:0] o_ind_rdata,
  output logic o_ind_valid,
  output logic o_extra_cycle,
  output logic o_stack_reset,
  output psi_ctx_t o_ctx_restore,
  output logic o_ctx_restore_valid
);

  typedef struct packed {
    logic [14:0] pc;
    logic [6:0] pc_high_latch;
    logic [4:0] sp;
    logic ovf;
    logic unf;
    logic fault_en;
    logic [7:0] interrupt_control;
    psi_ctx_t shad;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [14:0] prog_addr;
    logic prog_rd;
    logic ind_pending;
    logic ind_zero;
    logic ind_valid;
    logic extra;
    logic stk_rst;
    psi_ctx_t ctx;
    logic ctx_v;
  } psi_state_t;

  psi_state_t s_q;
  psi_state_t s_d;
  logic [14:0] stack_q [STK_DEPTH];
  logic [2:0] strap_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;

  // linear region: 80 byte blocks per bank, bank gpr starts at 0x20
  function automatic logic [11:0] lin_map(input logic [15:0] a);
    logic [15:0] off;
    logic [15:0] bank;
    logic [15:0] idx;
    off = a - IND_LIN_BASE;
    bank = off / 16'd80;
    idx = off - bank * 16'd80;
    lin_map = bank[4:0] * 12'h080 + GPR_BASE[11:0] + idx[11:0];
  endfunction

  function automatic logic is_port(input logic [15:0] a);
    is_port = (a[15:12] == 4'h0) && (a[6:0] == IND_PORT0[6:0] || a[6:0] == IND_PORT1[6:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strap sampling: pin passes three flops, change taken when last two agree
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      strap_q <= 3'b000;
    else
      strap_q <= {strap_q[1:0], i_cfg_reset_en_pin};
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic [15:0] ind_a;
  logic [14:0] tos;
  logic [14:0] pc_inc;
  logic [4:0] sp_push;
  logic [11:0] byte_idx;
  logic push_w;
  logic [14:0] push_val;
  logic [3:0] push_slot;
  logic [3:0] tos_slot;
  logic tos_wr;
  logic [14:0] tos_val;
  logic apb_acc;
  logic ovf_ev;
  logic unf_ev;

  always_comb
  begin
    s_d = s_q;
    push_w = 1'b0;
    push_val = s_q.pc;
    push_slot = 4'h0;
    tos_wr = 1'b0;
    tos_val = 15'h0000;
    tos_slot = s_q.sp[3:0];
    tos = stack_q[s_q.sp[3:0]];
    pc_inc = s_q.pc + 15'h0001;
    sp_push = s_q.sp + 5'h01;
    ind_a = i_ind.sel ? ptr1_q : ptr0_q;
    byte_idx = i_paddr[13:2];
    apb_acc = i_psel && i_penable && !s_q.pready;
    ovf_ev = 1'b0;
    unf_ev = 1'b0;
    s_d.mem_rd = 1'b0;
    s_d.mem_wr = 1'b0;
    s_d.prog_rd = 1'b0;
    s_d.ind_valid = 1'b0;
    s_d.extra = 1'b0;
    s_d.stk_rst = 1'b0;
    s_d.ctx_v = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (strap_q[2] == strap_q[1])
      s_d.fault_en = strap_q[2];
    // pc loading
    case (i_cmd.op)
      PSI_PC_WRLOW: s_d.pc = {s_q.pc_high_latch, i_cmd.wdata};
      PSI_PC_CALL, PSI_PC_CALL_VIA_W, PSI_PC_IRQ:
      begin
        // push: index up first, then store pc plus one
        if (s_q.sp == STK_LAST)
        begin
          s_d.ovf = 1'b1;
          ovf_ev = 1'b1;
          s_d.stk_rst = s_q.fault_en;
        end
        s_d.sp = (s_q.sp == STK_EMPTY) ? 5'h00 : {1'b0, sp_push[3:0]};
        push_w = 1'b1;
        push_slot = sp_push[3:0];
        push_val = pc_inc;
        if (i_cmd.op == PSI_PC_CALL)
          s_d.pc = {s_q.pc_high_latch[6:3], i_cmd.operand};
        else if (i_cmd.op == PSI_PC_CALL_VIA_W)
          s_d.pc = {s_q.pc_high_latch, i_cmd.working_register};
        else
        begin
          s_d.pc = 15'h0004;
          s_d.shad = '{working_register: i_cmd.working_register, flags: i_cmd.flags, bsr: i_cmd.bsr,
                       pc_high_latch: s_q.pc_high_latch, ptr0: ptr0_q, ptr1: ptr1_q};
        end
      end
      PSI_PC_BRW: s_d.pc = pc_inc + {7'h00, i_cmd.working_register};
      PSI_PC_BRA: s_d.pc = pc_inc + {{6{i_cmd.operand[8]}}, i_cmd.operand[8:0]};
      PSI_PC_RET:
      begin
        // pop: read entry then move index down
        s_d.pc = tos;
        if (s_q.sp == STK_EMPTY)
        begin
          s_d.unf = 1'b1;
          unf_ev = 1'b1;
          s_d.stk_rst = s_q.fault_en;
        end
        else
          s_d.sp = s_q.sp - 5'h01;
        if (i_cmd.return_from_interrupt)
        begin
          s_d.ctx = s_q.shad;
          s_d.ctx_v = 1'b1;
        end
      end
      default: s_d.pc = s_q.pc;
    endcase
    // indirect access
    if (i_ind.valid)
    begin
      s_d.ind_valid = 1'b1;
      s_d.ind_zero = 1'b0;
      if (ind_a[15])
      begin
        s_d.prog_addr = ind_a[14:0];
        s_d.prog_rd = !i_ind.wr;
        s_d.extra = 1'b1;
        s_d.ind_pending = 1'b1;
      end
      else if (ind_a <= IND_TRAD_END && is_port(ind_a))
        s_d.ind_zero = 1'b1;
      else if (ind_a <= IND_TRAD_END)
      begin
        s_d.mem_addr = ind_a[11:0];
        s_d.mem_rd = !i_ind.wr;
        s_d.mem_wr = i_ind.wr;
        s_d.mem_wdata = i_ind.wdata;
      end
      else if (ind_a >= IND_LIN_BASE && ind_a <= IND_LIN_END)
      begin
        s_d.mem_addr = lin_map(ind_a);
        s_d.mem_rd = !i_ind.wr;
        s_d.mem_wr = i_ind.wr;
        s_d.mem_wdata = i_ind.wdata;
      end
      else
        s_d.ind_zero = 1'b1;
    end
    // apb slave, one wait state
    if (i_psel && !i_penable)
      s_d.pready = 1'b0;
    if (apb_acc)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (i_pwrite)
      begin
        if (byte_idx == IDX_PC_LOW)
          s_d.pc = {s_q.pc_high_latch, i_pwdata[7:0]};
        else if (byte_idx == IDX_PC_LATCH)
          s_d.pc_high_latch = i_pwdata[6:0];
        else if (byte_idx == IDX_INTERRUPT_CONTROL)
          s_d.interrupt_control = i_pwdata[7:0];
        else if (byte_idx == IDX_STK_IDX)
          s_d.sp = i_pwdata[4:0];
        else if (byte_idx == IDX_TOS_LOW)
        begin
          tos_wr = 1'b1;
          tos_val = {tos[14:8], i_pwdata[7:0]};
        end
        else if (byte_idx == IDX_TOS_HIGH)
        begin
          tos_wr = 1'b1;
          tos_val = {i_pwdata[6:0], tos[7:0]};
        end
        else if (byte_idx == IDX_FLAGS)
        begin
          // a fault in the same cycle as the clear keeps its flag set
          s_d.ovf = (s_q.ovf & ~i_pwdata[0]) | ovf_ev;
          s_d.unf = (s_q.unf & ~i_pwdata[1]) | unf_ev;
        end
        else if (byte_idx == IDX_W_SHAD)
          s_d.shad.working_register = i_pwdata[7:0];
        else if (byte_idx == IDX_ST_SHAD)
          s_d.shad.flags = i_pwdata[2:0];
        else if (byte_idx == IDX_BANK_SELECT_SHADOW)
          s_d.shad.bsr = i_pwdata[4:0];
        else if (byte_idx == IDX_PCL_SHAD)
          s_d.shad.pc_high_latch = i_pwdata[6:0];
        else if (byte_idx == IDX_P0L_SHAD)
          s_d.shad.ptr0[7:0] = i_pwdata[7:0];
        else if (byte_idx == IDX_P0H_SHAD)
          s_d.shad.ptr0[15:8] = i_pwdata[7:0];
        else if (byte_idx == IDX_P1L_SHAD)
          s_d.shad.ptr1[7:0] = i_pwdata[7:0];
        else if (byte_idx == IDX_P1H_SHAD)
          s_d.shad.ptr1[15:8] = i_pwdata[7:0];
        else if (byte_idx != IDX_CFG)
          s_d.pslverr = 1'b1;
      end
      else
      begin
        if (byte_idx == IDX_PC_LOW)
          s_d.prdata[7:0] = s_q.pc[7:0];
        else if (byte_idx == IDX_PC_LATCH)
          s_d.prdata[6:0] = s_q.pc_high_latch;
        else if (byte_idx == IDX_INTERRUPT_CONTROL)
          s_d.prdata[7:0] = s_q.interrupt_control;
        else if (byte_idx == IDX_STK_IDX)
          s_d.prdata[4:0] = s_q.sp;
        else if (byte_idx == IDX_TOS_LOW)
          s_d.prdata[7:0] = tos[7:0];
        else if (byte_idx == IDX_TOS_HIGH)
          s_d.prdata[6:0] = tos[14:8];
        else if (byte_idx == IDX_FLAGS)
          s_d.prdata[1:0] = {s_q.unf, s_q.ovf};
        else if (byte_idx == IDX_CFG)
          s_d.prdata[0] = s_q.fault_en;
        else if (byte_idx == IDX_W_SHAD)
          s_d.prdata[7:0] = s_q.shad.working_register;
        else if (byte_idx == IDX_ST_SHAD)
          s_d.prdata[2:0] = s_q.shad.flags;
        else if (byte_idx == IDX_BANK_SELECT_SHADOW)
          s_d.prdata[4:0] = s_q.shad.bsr;
        else if (byte_idx == IDX_PCL_SHAD)
          s_d.prdata[6:0] = s_q.shad.pc_high_latch;
        else if (byte_idx == IDX_P0L_SHAD)
          s_d.prdata[7:0] = s_q.shad.ptr0[7:0];
        else if (byte_idx == IDX_P0H_SHAD)
          s_d.prdata[7:0] = s_q.shad.ptr0[15:8];
        else if (byte_idx == IDX_P1L_SHAD)
          s_d.prdata[7:0] = s_q.shad.ptr1[7:0];
        else if (byte_idx == IDX_P1H_SHAD)
          s_d.prdata[7:0] = s_q.shad.ptr1[15:8];
        else
          s_d.pslverr = 1'b1;
      end
    end
    // a stack fault reset returns pc and index to their reset state
    if (s_d.stk_rst)
    begin
      s_d.pc = PC_RESET;
      s_d.sp = STK_EMPTY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer pair: loaded by the decoder through the restore path only here
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end
    else if (s_q.ctx_v)
    begin
      ptr0_q <= s_q.ctx.ptr0;
      ptr1_q <= s_q.ctx.ptr1;
    end
  end

  // stack memory has no reset; entries are undefined until pushed
  always_ff @(posedge i_sys_clk)
  begin
    if (push_w)
      stack_q[push_slot] <= push_val;
    else if (tos_wr)
      stack_q[tos_slot] <= tos_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '0;
      s_q.pc <= PC_RESET;
      s_q.sp <= STK_EMPTY;
      s_q.interrupt_control <= INTERRUPT_CONTROL_RESET;
    end
    else
      s_q <= s_d;
  end

  // program memory and data memory answers
  logic [7:0] ind_data;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      ind_data <= 8'h00;
    else if (s_q.ind_zero)
      ind_data <= 8'h00;
    else if (s_q.prog_rd)
      ind_data <= i_prog_rdata;
    else
      ind_data <= i_mem_rdata;
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_pc = s_q.pc;
  assign o_mem_addr = s_q.mem_addr;
  assign o_mem_rd = s_q.mem_rd;
  assign o_mem_wr = s_q.mem_wr;
  assign o_mem_wdata = s_q.mem_wdata;
  assign o_prog_addr = s_q.prog_addr;
  assign o_prog_rd = s_q.prog_rd;
  assign o_ind_rdata = ind_data;
  assign o_ind_valid = s_q.ind_valid;
  assign o_extra_cycle = s_q.extra;
  assign o_stack_reset = s_q.stk_rst;
  assign o_ctx_restore = s_q.ctx;
  assign o_ctx_restore_valid = s_q.ctx_v;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence call_seq;
    i_cmd.op == PSI_PC_CALL && !apb_acc;
  endsequence

  a_pc_reset_zero: assert property (@(posedge i_sys_clk) $fell(i_rst) |-> o_pc == 15'h0000)
    else $error("pc not zero after reset");
  a_wrlow_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.op == PSI_PC_WRLOW && !apb_acc |=> o_pc[14:8] == $past(s_q.pc_high_latch))
    else $error("pc high not from latch");
  a_call_target: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    call_seq |=> o_stack_reset || o_pc == {$past(s_q.pc_high_latch[6:3]), $past(i_cmd.operand)})
    else $error("call target wrong");
  a_brw_target: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.op == PSI_PC_BRW && !apb_acc |=> o_pc == $past(pc_inc) + {7'h00, $past(i_cmd.working_register)})
    else $error("branch by w target wrong");
  a_push_index: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    call_seq and s_q.sp == 5'h03 |=> s_q.sp == 5'h04)
    else $error("push index wrong");
  a_latch_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    call_seq |=> $stable(s_q.pc_high_latch))
    else $error("latch changed by push");
  a_under_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.op == PSI_PC_RET && s_q.sp == STK_EMPTY |=> s_q.unf)
    else $error("underflow not flagged");
  a_fault_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cmd.op == PSI_PC_RET && s_q.sp == STK_EMPTY && s_q.fault_en |=> o_stack_reset ##1 !o_stack_reset)
    else $error("fault reset missing");
endmodule // psi_unit

// ### include/psi_pkg.sv
package psi_pkg;
  // apb word indices of the registers (byte address is index times four), printed offsets kept as indices
  localparam logic [11:0] IDX_INTERRUPT_CONTROL = 12'h0F8B;
  localparam logic [11:0] IDX_ST_SHAD = 12'h0FE4;
  localparam logic [11:0] IDX_W_SHAD = 12'h0FE5;
  localparam logic [11:0] IDX_BANK_SELECT_SHADOW = 12'h0FE6;
  localparam logic [11:0] IDX_PCL_SHAD = 12'h0FE7;
  localparam logic [11:0] IDX_P0L_SHAD = 12'h0FE8;
  localparam logic [11:0] IDX_P0H_SHAD = 12'h0FE9;
  localparam logic [11:0] IDX_P1L_SHAD = 12'h0FEA;
  localparam logic [11:0] IDX_P1H_SHAD = 12'h0FEB;
  localparam logic [11:0] IDX_STK_IDX = 12'h0FED;
  localparam logic [11:0] IDX_TOS_LOW = 12'h0FEE;
  localparam logic [11:0] IDX_TOS_HIGH = 12'h0FEF;
  localparam logic [11:0] IDX_PC_LOW = 12'h0F82;
  localparam logic [11:0] IDX_PC_LATCH = 12'h0F8A;
  localparam logic [11:0] IDX_CFG = 12'h0FF0;
  localparam logic [11:0] IDX_FLAGS = 12'h0FF1;
  // reset values and counts
  localparam logic [4:0] STK_EMPTY = 5'h1F;
  localparam logic [4:0] STK_LAST = 5'h0F;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
  localparam int STK_DEPTH = 16;
  // indirect map edges
  localparam logic [15:0] IND_TRAD_END = 16'h0FFF;
  localparam logic [15:0] IND_LIN_BASE = 16'h2000;
  localparam logic [15:0] IND_LIN_END = 16'h29AF;
  localparam logic [11:0] IND_PORT0 = 12'h000;
  localparam logic [11:0] IND_PORT1 = 12'h001;
  localparam logic [11:0] GPR_BASE = 12'h020;
  localparam logic [6:0] BANK_SIZE = 7'h50;
  localparam logic [6:0] BANK_STRIDE = 7'h00;

  // pc load request from the decoder
  typedef enum logic [2:0]
  {
    PSI_PC_NONE = 3'b000,
    PSI_PC_WRLOW = 3'b001,
    PSI_PC_CALL = 3'b010,
    PSI_PC_CALL_VIA_W = 3'b011,
    PSI_PC_BRW = 3'b100,
    PSI_PC_BRA = 3'b101,
    PSI_PC_RET = 3'b110,
    PSI_PC_IRQ = 3'b111
  } psi_pcop_t;

  typedef struct packed {
    psi_pcop_t op;
    logic [10:0] operand;
    logic [7:0] wdata;
    logic [7:0] working_register;
    logic return_from_interrupt;
    logic [2:0] flags;
    logic [4:0] bsr;
  } psi_cmd_t;

  typedef struct packed {
    logic valid;
    logic sel;
    logic wr;
    logic [7:0] wdata;
  } psi_ind_t;

  typedef struct packed {
    logic [7:0] working_register;
    logic [2:0] flags;
    logic [4:0] bsr;
    logic [6:0] pc_high_latch;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
  } psi_ctx_t;
endpackage

// ### verification/psi_mem_model.sv
module psi_mem_model
  import psi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_mem_rd,
  input wire logic [11:0] i_mem_addr,
  input wire logic i_prog_rd,
  input wire logic [14:0] i_prog_addr,
  output logic [7:0] o_mem_rdata,
  output logic [7:0] o_prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk_q = 8'h5A;
  ////////////////////////////////////////////////////////////////
  // data only while a strobe stands; otherwise a changing pattern
  // so that a late sample never sees the last word by luck
  always @(posedge i_sys_clk)
    junk_q <= ~junk_q + 8'h01;
  // answer while the strobe stands: the unit takes it at the edge ending the strobe
  assign o_mem_rdata = (i_mem_rd === 1'b1) ? (i_mem_addr[7:0] ^ 8'hA5) : junk_q;
  assign o_prog_rdata = (i_prog_rd === 1'b1) ? i_prog_addr[7:0] : ~junk_q;
endmodule // psi_mem_model

// ### verification/psi_unit_tb.sv
module psi_unit_tb
  import psi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 0, i_rst = 1, i_cfg_reset_en_pin = 0;
  psi_cmd_t i_cmd = '0;
  psi_ind_t i_ind = '0;
  logic [7:0] i_mem_rdata, i_prog_rdata;
  logic i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [15:0] i_paddr = 16'h0000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata;
  logic o_pready, o_pslverr, o_mem_rd, o_mem_wr, o_prog_rd, o_ind_valid, o_extra_cycle;
  logic o_stack_reset, o_ctx_restore_valid;
  logic [14:0] o_pc, o_prog_addr;
  logic [11:0] o_mem_addr, mad_cap;
  logic [7:0] o_mem_wdata, o_ind_rdata, ind_cap, mwd_cap;
  psi_ctx_t o_ctx_restore, ctx_cap, ctx_m;
  int seed = 15, err_total = 0, n_tests = 0, n_sr = 0, n_ctx = 0, n_mwr = 0, n_ext = 0;
  logic [14:0] stk [16];
  logic [14:0] pc_m;
  logic [4:0] sidx;
  logic [6:0] lat_m;
  logic [31:0] rd;
  logic er, ind_v1 = 1'b0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  psi_unit dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg_reset_en_pin(i_cfg_reset_en_pin),
    .i_cmd(i_cmd), .i_ind(i_ind), .i_mem_rdata(i_mem_rdata), .i_prog_rdata(i_prog_rdata),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_pc(o_pc), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .o_prog_addr(o_prog_addr), .o_prog_rd(o_prog_rd),
    .o_ind_rdata(o_ind_rdata), .o_ind_valid(o_ind_valid), .o_extra_cycle(o_extra_cycle),
    .o_stack_reset(o_stack_reset), .o_ctx_restore(o_ctx_restore),
    .o_ctx_restore_valid(o_ctx_restore_valid));
  psi_mem_model mem (.i_sys_clk(i_sys_clk), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
    .i_prog_rd(o_prog_rd), .i_prog_addr(o_prog_addr), .o_mem_rdata(i_mem_rdata),
    .o_prog_rdata(i_prog_rdata));
  ////////////////////////////////////////////////////////////////
  // pulse watchers: single-cycle outputs are counted where they stand
  always @(posedge i_sys_clk)
  begin
    if (o_stack_reset === 1'b1) n_sr <= n_sr + 1;
    if (o_mem_wr === 1'b1)
    begin
      n_mwr <= n_mwr + 1;
      mad_cap <= o_mem_addr;
      mwd_cap <= o_mem_wdata;
    end
    if (o_extra_cycle === 1'b1) n_ext <= n_ext + 1;
    // read data stands the cycle after the valid pulse
    ind_v1 <= (o_ind_valid === 1'b1);
    if (ind_v1) ind_cap <= o_ind_rdata;
    if (o_ctx_restore_valid === 1'b1)
    begin
      n_ctx <= n_ctx + 1;
      ctx_cap <= o_ctx_restore;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
      k++;
    end
    while (o_pready !== 1'b1 && k < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      conclude();
    end
  endtask
  // one indirect access, then time for strobe and read data to settle
  task automatic ind_op(input logic sl, input logic w, input logic [7:0] wd);
    @(posedge i_sys_clk);
    i_ind <= '{valid: 1'b1, sel: sl, wr: w, wdata: wd};
    @(posedge i_sys_clk);
    i_ind <= '0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  // expected next index of a push, and target of a relative branch
  function automatic logic [4:0] f_push(input logic [4:0] i);
    return (i == STK_EMPTY || i == STK_LAST) ? 5'h00 : i + 5'h01;
  endfunction
  function automatic logic [14:0] f_bra(input logic [14:0] p, input logic [10:0] o);
    return p + 15'h0001 + {{6{o[8]}}, o[8:0]}; // nine-bit signed offset
  endfunction
  task automatic op(input psi_pcop_t o, input logic [10:0] opd, input logic [7:0] w,
    input logic rf);
    psi_cmd_t c;
    c = '0;
    c.op = o;
    c.operand = opd;
    c.wdata = w;
    c.working_register = w;
    c.return_from_interrupt = rf;
    c.flags = $random(seed);
    c.bsr = $random(seed);
    if (o == PSI_PC_CALL || o == PSI_PC_CALL_VIA_W || o == PSI_PC_IRQ)
    begin
      sidx = f_push(sidx);
      stk[sidx[3:0]] = pc_m + 15'h0001; // return address is the next instruction
    end
    case (o)
      PSI_PC_WRLOW, PSI_PC_CALL_VIA_W: pc_m = {lat_m, w};
      PSI_PC_CALL: pc_m = {lat_m[6:3], opd};
      PSI_PC_BRW: pc_m = pc_m + 15'h0001 + {7'h00, w};
      PSI_PC_BRA: pc_m = f_bra(pc_m, opd);
      PSI_PC_IRQ:
      begin
        pc_m = 15'h0004;
        ctx_m = '0;
        ctx_m.working_register = w;
        ctx_m.flags = c.flags;
        ctx_m.bsr = c.bsr;
        ctx_m.pc_high_latch = lat_m;
      end
      PSI_PC_RET:
        // underflow: fault reset clears pc, else the index-15 slot is loaded
        if (sidx == STK_EMPTY) pc_m = i_cfg_reset_en_pin ? PC_RESET : stk[15];
        else
        begin
          pc_m = stk[sidx[3:0]];
          sidx = (sidx == 5'h00) ? STK_EMPTY : sidx - 5'h01;
        end
      default: ;
    endcase
    @(posedge i_sys_clk);
    i_cmd <= c;
    @(posedge i_sys_clk);
    i_cmd.op <= PSI_PC_NONE;
    #1;
    chk("pc", {17'h0, pc_m}, {17'h0, o_pc});
    apb(0, IDX_STK_IDX, 0);
    chk("stack index", {27'h0, sidx}, rd);
  endtask
  task automatic rst_all();
    i_rst <= 1'b1;
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    pc_m = PC_RESET;
    sidx = STK_EMPTY;
    lat_m = 7'h00;
    #1;
    chk("pc reset", 32'h0000_0000, {17'h0, o_pc});
    apb(0, IDX_STK_IDX, 0);
    chk("index reset", {27'h0, STK_EMPTY}, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #2_000_000;
    err_total++;
    conclude();
  end
  initial
  begin
    rst_all();
    apb(0, IDX_INTERRUPT_CONTROL, 0);
    chk("interrupt_control", {24'h0, INTERRUPT_CONTROL_RESET}, rd);
    apb(0, 12'hFEC, 0);
    chk("unmapped err", 32'h1, {31'h0, er});
    lat_m = $random(seed);
    apb(1, IDX_PC_LATCH, {25'h0, lat_m});
    apb(0, IDX_PC_LATCH, 0);
    chk("latch", {25'h0, lat_m}, {25'h0, rd[6:0]});
    op(PSI_PC_WRLOW, 0, $random(seed), 0);
    apb(1, IDX_PC_LOW, 32'h0000_00C3);
    pc_m = {lat_m, 8'hC3};
    #1;
    chk("pc low write", {17'h0, pc_m}, {17'h0, o_pc});
    op(PSI_PC_CALL, $random(seed), 0, 0);
    op(PSI_PC_CALL_VIA_W, 0, $random(seed), 0);
    op(PSI_PC_BRW, 0, 8'hFF, 0);
    op(PSI_PC_BRA, 11'h1F0, 0, 0);
    op(PSI_PC_BRA, 11'h0FF, 0, 0);
    apb(0, IDX_TOS_LOW, 0);
    chk("top low", {24'h0, stk[sidx[3:0]][7:0]}, rd);
    apb(0, IDX_TOS_HIGH, 0);
    chk("top high", {25'h0, stk[sidx[3:0]][14:8]}, {25'h0, rd[6:0]});
    apb(1, IDX_TOS_LOW, 32'h0000_0066);
    stk[sidx[3:0]][7:0] = 8'h66;
    op(PSI_PC_RET, 0, 0, 0);
    op(PSI_PC_RET, 0, 0, 0);
    apb(0, IDX_PC_LATCH, 0);
    chk("latch kept", {25'h0, lat_m}, {25'h0, rd[6:0]});
    // seventeen pushes wrap onto the first entry
    repeat (17) op(PSI_PC_CALL, $random(seed), 0, 0);
    apb(0, IDX_FLAGS, 0);
    chk("over flag", 32'h1, {31'h0, rd[0]});
    op(PSI_PC_RET, 0, 0, 0);
    op(PSI_PC_RET, 0, 0, 0);
    apb(0, IDX_FLAGS, 0);
    chk("under flag", 32'h1, {31'h0, rd[1]});
    chk("no fault reset", 0, n_sr);
    apb(1, IDX_FLAGS, 32'h0000_0003);
    i_cfg_reset_en_pin <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    apb(0, IDX_CFG, 0);
    chk("fault enable", 32'h1, {31'h0, rd[0]});
    op(PSI_PC_RET, 0, 0, 0);
    repeat (3) @(posedge i_sys_clk);
    chk("fault reset", 1, n_sr);
    apb(0, IDX_FLAGS, 0);
    chk("under flag on", 32'h2, {30'h0, rd[1:0]});
    i_cfg_reset_en_pin <= 1'b0;
    // interrupt entry saves context, return restores it
    op(PSI_PC_IRQ, 0, $random(seed), 0);
    apb(0, IDX_W_SHAD, 0);
    chk("w shadow", {24'h0, ctx_m.working_register}, rd);
    op(PSI_PC_RET, 0, 0, 1);
    repeat (3) @(posedge i_sys_clk);
    chk("restore count", 1, n_ctx);
    chk("restore ctx", ctx_m[31:0], ctx_cap[31:0]);
    chk("restore ctx hi", {9'h0, ctx_m[54:32]}, {9'h0, ctx_cap[54:32]});
    // pointer at reset aims at the port itself
    ind_cap = 8'hFF;
    @(posedge i_sys_clk);
    i_ind <= '{valid: 1'b1, sel: 1'b0, wr: 1'b1, wdata: 8'h3C};
    @(posedge i_sys_clk);
    i_ind <= '{valid: 1'b1, sel: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(posedge i_sys_clk);
    i_ind <= '0;
    repeat (4) @(posedge i_sys_clk);
    chk("port write blocked", 0, n_mwr);
    chk("port reads zero", 0, {24'h0, ind_cap});
    // restored pointers reach program memory and the linear view
    apb(1, IDX_P0H_SHAD, 32'h0000_0080);
    apb(1, IDX_P0L_SHAD, 32'h0000_0034);
    apb(1, IDX_P1H_SHAD, 32'h0000_0020);
    apb(1, IDX_P1L_SHAD, 32'h0000_0053);
    op(PSI_PC_RET, 0, 0, 1);
    ind_op(0, 0, 8'h00);
    chk("prog byte", 32'h0000_0034, {24'h0, ind_cap});
    chk("extra cycle", 1, n_ext);
    // 0x2053 is bank 1 offset 3, so 0x0A3; the model answers address xor a5
    ind_op(1, 0, 8'h00);
    chk("linear byte", 32'h0000_0006, {24'h0, ind_cap});
    ind_op(1, 1, 8'h5E);
    ind_op(0, 1, 8'h77);
    chk("linear addr", 32'h0000_00A3, {20'h0, mad_cap});
    chk("linear wdata", 32'h0000_005E, {24'h0, mwd_cap});
    chk("prog no write", 1, n_mwr);
    chk("extra count", 2, n_ext);
    // random traffic with the model tracking every step
    repeat (30)
      op(psi_pcop_t'(3'd1 + ($unsigned($random(seed)) % 6)), $random(seed), $random(seed), 0);
    rst_all();
    conclude();
  end
endmodule // psi_unit_tb
